// ### rtl/tmz_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// shared divider link between the timer core and the divider
interface tmz_div_if;
   import tmz_pkg::*;
   logic src_tick;
   logic clear;
   logic [OPT_RATIO_W-1:0] ratio;
   logic to_watchdog;
   logic out_tick;
   modport core (output src_tick, output clear, output ratio, output to_watchdog, input out_tick);
   modport div (input src_tick, input clear, input ratio, input to_watchdog, output out_tick);
endinterface
`default_nettype wire

// ### rtl/tmz_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tmz_divider
   import tmz_pkg::*;
#(
   parameter int WIDTH = DIV_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // divider link
   tmz_div_if.div dl
);
   // ------------------------------------------------------------
   // divider count, never visible to software
   // ------------------------------------------------------------
   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] next_cnt;
   logic [WIDTH-1:0] term;
   logic [3:0] shift;
   logic bypass;

   // counter ratios 1:2..1:256; watchdog ratios 1:1..1:128
   assign shift = dl.to_watchdog ? {1'b0, dl.ratio} : ({1'b0, dl.ratio} + 4'h1);
   assign term = WIDTH'((9'h001 << shift) - 9'h001);
   assign bypass = dl.to_watchdog && (dl.ratio == '0);
   assign next_cnt = (cnt == term) ? '0 : cnt + WIDTH'(1);

   // one output tick per full period
   assign dl.out_tick = dl.src_tick && (bypass || (cnt == term));

   // count cleared only by reset or the link clear (count write or watchdog clear)
   always_ff @(posedge clk) begin
      if (rst || dl.clear) begin
         cnt <= '0;
      end else if (dl.src_tick) begin
         cnt <= next_cnt;
      end
   end
endmodule
`default_nettype wire

// ### rtl/tmz_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tmz_edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // pin and edge choice
   input wire logic pin,
   input wire logic falling,
   // chosen edge seen
   output logic edge_pulse
);
   // ------------------------------------------------------------
   // two-stage synchroniser plus edge history
   // ------------------------------------------------------------
   logic meta;
   logic sync;
   logic prev;

   // only the second stage feeds the edge detector
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   // rising when clear, falling when set
   assign edge_pulse = falling ? (prev & ~sync) : (~prev & sync);
endmodule
`default_nettype wire

// ### rtl/tmz_pkg.sv
package tmz_pkg;
   // ------------------------------------------------------------
   // register map (index space of the core's plain port)
   // ------------------------------------------------------------
   localparam logic [8:0] ADDR_TIMER_COUNT = 9'h001;
   localparam logic [8:0] ADDR_INTERRUPT_CONTROL = 9'h00b;
   localparam logic [8:0] ADDR_OPTION_CONFIG = 9'h081;
   localparam logic [8:0] ADDR_IRQ_STATUS = 9'h090;
   localparam logic [8:0] ADDR_IRQ_MASK = 9'h091;
   localparam int ADDR_W = 9;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OPT_CLOCK_SOURCE_SELECT = 5;
   localparam int OPT_EDGE_SELECT = 4;
   localparam int OPT_DIVIDER_ASSIGN = 3;
   localparam int OPT_RATIO_LO = 0;
   localparam int OPT_RATIO_W = 3;
   localparam int ICR_OVERFLOW_FLAG = 2;
   localparam int ICR_OVERFLOW_IRQ_ENABLE = 5;
   localparam int EVT_OVERFLOW = 0;
   localparam int EVT_WDT_TICK = 1;
   localparam int EVT_W = 2;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] ICR_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [1:0] WRITE_INHIBIT_CYCLES = 2'h2;
   localparam int INSTR_CYCLE_NS = 40;
   localparam int CLK_PERIOD_NS = 10;
   localparam int INSTR_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;
   localparam int DIV_W = 8;
endpackage

// ### rtl/tmz_timer0.sv
// Functional notes
// - source select clear counts instruction cycles
// - count write blocks two following cycles
// - source select set counts pin edges
// - edge select chooses rising or falling
// - pin synchronised, then delayed update
// - one 8-bit divider, counter or watchdog
// - divider count never software visible
// - assign bit and ratio at option bits 3:0
// - counter ratios 1:2 to 1:256
// - watchdog ratios 1:1 to 1:128
// - count write clears divider when counter owns
// - watchdog clear clears divider when watchdog owns
// - wrap FFh to 00h sets overflow flag
// - enable bit masks; software clears flag
// - counter stops in sleep, no wake
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0
   import tmz_pkg::*;
#(
   parameter int CLKS_PER_INSTR = INSTR_CLKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // core state
   input wire logic sleep,
   input wire logic watchdog_clear_instr,
   // external count source
   input wire logic count_input_pin,
   // watchdog side
   input wire logic watchdog_tick,
   output logic watchdog_post_tick,
   output logic watchdog_reset,
   // interrupts
   output logic overflow_irq,
   output logic irq
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   localparam int PH_W = $clog2(CLKS_PER_INSTR + 1);

   logic [7:0] timer_count;
   logic [7:0] interrupt_control;
   logic [7:0] option_config;
   logic [EVT_W-1:0] irq_status;
   logic [EVT_W-1:0] irq_mask;
   logic [PH_W-1:0] phase;
   logic [1:0] inhibit;
   logic [7:0] next_count;
   logic [7:0] next_rdata;

   wire clock_source_select = option_config[OPT_CLOCK_SOURCE_SELECT];
   wire edge_select = option_config[OPT_EDGE_SELECT];
   wire divider_assign = option_config[OPT_DIVIDER_ASSIGN];
   wire [OPT_RATIO_W-1:0] divider_ratio = option_config[OPT_RATIO_LO +: OPT_RATIO_W];
   wire overflow_flag = interrupt_control[ICR_OVERFLOW_FLAG];
   wire overflow_irq_enable = interrupt_control[ICR_OVERFLOW_IRQ_ENABLE];

   wire instr_tick;
   wire pin_edge;
   wire src_event;
   wire count_step;
   wire wrap;
   wire wr_count;
   wire wr_icr;
   wire wr_opt;
   wire wr_stat;
   wire wr_mask;
   wire [EVT_W-1:0] evt;

   tmz_div_if dlink ();

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
      hit = (a == target);
   endfunction

   assign wr_count = wr && hit(addr, ADDR_TIMER_COUNT);
   assign wr_icr = wr && hit(addr, ADDR_INTERRUPT_CONTROL);
   assign wr_opt = wr && hit(addr, ADDR_OPTION_CONFIG);
   assign wr_stat = wr && hit(addr, ADDR_IRQ_STATUS);
   assign wr_mask = wr && hit(addr, ADDR_IRQ_MASK);

   // ------------------------------------------------------------
   // instruction cycle phase
   // ------------------------------------------------------------
   // phase frozen in sleep so no tick occurs
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= '0;
      end else if (!sleep) begin
         phase <= (phase == PH_W'(CLKS_PER_INSTR - 1)) ? '0 : phase + PH_W'(1);
      end
   end
   assign instr_tick = !sleep && (phase == PH_W'(CLKS_PER_INSTR - 1));

   // ------------------------------------------------------------
   // pin synchroniser and edge pick
   // ------------------------------------------------------------
   tmz_edge_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pin(count_input_pin),
      .falling(edge_select),
      .edge_pulse(pin_edge)
   );

   assign src_event = clock_source_select ? (pin_edge && !sleep) : instr_tick;

   // ------------------------------------------------------------
   // shared divider
   // ------------------------------------------------------------
   // one divider, owner picked by assign bit
   // ownership and ratio from option bits 3:0
   assign dlink.to_watchdog = divider_assign;
   assign dlink.ratio = divider_ratio;
   assign dlink.src_tick = divider_assign ? watchdog_tick : src_event;
   // count write clears it while counter owns
   // watchdog clear clears it while watchdog owns
   assign dlink.clear = divider_assign ? watchdog_clear_instr : wr_count;

   tmz_divider #(
      .WIDTH(DIV_W)
   ) u_div (
      .clk(clk),
      .rst(rst),
      .dl(dlink)
   );

   // reassignment mid-period simply restarts nothing; software sequences it
   assign watchdog_post_tick = divider_assign && dlink.out_tick;
   assign watchdog_reset = watchdog_clear_instr;

   // with the divider owned, step only on its period
   assign count_step = (divider_assign ? src_event : dlink.out_tick) && (inhibit == 2'h0);
   assign next_count = timer_count + 8'h01;
   assign wrap = count_step && !wr_count && (timer_count == 8'hff);

   // ------------------------------------------------------------
   // count register and write inhibit
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_count <= COUNT_RESET;
      end else if (wr_count) begin
         timer_count <= wdata;
      end else if (count_step) begin
         timer_count <= next_count;
      end
   end

   // two instruction cycles of inhibit after a write
   always_ff @(posedge clk) begin
      if (rst) begin
         inhibit <= 2'h0;
      end else if (wr_count) begin
         inhibit <= WRITE_INHIBIT_CYCLES;
      end else if (instr_tick && inhibit != 2'h0) begin
         inhibit <= inhibit - 2'h1;
      end
   end

   // ------------------------------------------------------------
   // option and interrupt control
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         option_config <= OPTION_RESET;
      end else if (wr_opt) begin
         option_config <= wdata;
      end
   end

   // wrap sets the flag, set beats a write clear
   always_ff @(posedge clk) begin
      if (rst) begin
         interrupt_control <= ICR_RESET;
      end else begin
         interrupt_control <= wr_icr ? wdata : interrupt_control;
         if (wrap) begin
            interrupt_control[ICR_OVERFLOW_FLAG] <= 1'b1;
         end
      end
   end

   // enable bit gates the overflow request
   assign overflow_irq = overflow_flag && overflow_irq_enable;

   // ------------------------------------------------------------
   // sticky event status, write one to clear
   // ------------------------------------------------------------
   assign evt[EVT_OVERFLOW] = wrap;
   assign evt[EVT_WDT_TICK] = watchdog_post_tick;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         irq_status <= (irq_status & ~(wr_stat ? wdata[EVT_W-1:0] : '0)) | evt;
         if (wr_mask) begin
            irq_mask <= wdata[EVT_W-1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ------------------------------------------------------------
   // read mux, data one cycle after the strobe
   // ------------------------------------------------------------
   // no address reaches the divider count
   always_comb begin
      next_rdata = 8'h00;
      unique case (1'b1)
         hit(addr, ADDR_TIMER_COUNT): next_rdata = timer_count;
         hit(addr, ADDR_INTERRUPT_CONTROL): next_rdata = interrupt_control;
         hit(addr, ADDR_OPTION_CONFIG): next_rdata = option_config;
         hit(addr, ADDR_IRQ_STATUS): next_rdata = {{(8-EVT_W){1'b0}}, irq_status};
         hit(addr, ADDR_IRQ_MASK): next_rdata = {{(8-EVT_W){1'b0}}, irq_mask};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module testbench;
   import tmz_pkg::*;
   logic clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_q = 1'b0, sleep = 1'b0, clr_i = 1'b0, wd_tick = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = 8'h00, v, e;
   logic [7:0] exp_q[$];
   wire logic pin, post, ovf, irq;
   wire logic [7:0] rdata;
   int n_fail = 0, checks = 0, n_post = 0, p;
   tmz_timer0 dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sleep(sleep), .watchdog_clear_instr(clr_i), .count_input_pin(pin), .watchdog_tick(wd_tick),
      .watchdog_post_tick(post), .watchdog_reset(), .overflow_irq(ovf), .irq(irq));
   tmz_pin_src src (.clk(clk), .pin(pin));
   // ----------------------------------------
   // clock, scoreboard and tick counter
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) rd_q <= rd;
   always @(posedge clk) if (post) n_post++;
   // read data only stands one cycle, so compare mid-cycle
   always @(negedge clk) begin
      if (rd_q) begin
         e = exp_q.pop_front();
         `CHK(rdata, e)
      end
   end
   // ----------------------------------------
   // bus and stimulus tasks
   // ----------------------------------------
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rd_exp(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(d);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // settle past the write inhibit, then wait out the synchroniser
   task automatic feed(input int n, input int h);
      repeat (12) @(posedge clk);
      src.pulses(n, h);
      repeat (8) @(posedge clk);
   endtask
   task automatic wd(input int n, input logic clr);
      repeat (n) begin
         @(posedge clk);
         wd_tick <= 1'b1;
         @(posedge clk);
         wd_tick <= 1'b0;
      end
      @(posedge clk);
      clr_i <= clr;
      @(posedge clk);
      clr_i <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic give_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      v = 8'($urandom(32'h8509));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_exp(ADDR_OPTION_CONFIG, OPTION_RESET);
      rd_exp(ADDR_INTERRUPT_CONTROL, ICR_RESET);
      rd_exp(ADDR_TIMER_COUNT, COUNT_RESET);
      rd_exp(9'h0ff, 8'h00);
      wr_reg(ADDR_OPTION_CONFIG, 8'h08);
      rd_exp(ADDR_OPTION_CONFIG, 8'h08);
      wr_reg(ADDR_TIMER_COUNT, 8'h7f);
      rd_exp(ADDR_TIMER_COUNT, 8'h7f);
      v = 8'($urandom_range(200, 0));
      wr_reg(ADDR_OPTION_CONFIG, 8'h28);
      wr_reg(ADDR_TIMER_COUNT, v);
      feed(5, 4);
      rd_exp(ADDR_TIMER_COUNT, v + 8'h05);
      wr_reg(ADDR_OPTION_CONFIG, 8'h38);
      feed(3, 2);
      rd_exp(ADDR_TIMER_COUNT, v + 8'h08);
      // every counter ratio; the write in mid-period must restart the divider
      for (int r = 0; r < 8; r++) begin
         p = 2 << r;
         wr_reg(ADDR_OPTION_CONFIG, 8'h20 | 8'(r));
         wr_reg(ADDR_TIMER_COUNT, 8'h00);
         feed(p - 1, 3);
         wr_reg(ADDR_TIMER_COUNT, 8'h10);
         feed(p - 1, 3);
         rd_exp(ADDR_TIMER_COUNT, 8'h10);
         feed(1, 3);
         rd_exp(ADDR_TIMER_COUNT, 8'h11);
      end
      wr_reg(ADDR_OPTION_CONFIG, 8'h28);
      wr_reg(ADDR_IRQ_MASK, 8'h01);
      wr_reg(ADDR_INTERRUPT_CONTROL, 8'h20);
      wr_reg(ADDR_TIMER_COUNT, 8'hfe);
      feed(1, 3);
      @(negedge clk);
      `CHK(ovf, 1'b0)
      feed(1, 3);
      @(negedge clk);
      `CHK({ovf, irq}, 2'b11)
      rd_exp(ADDR_INTERRUPT_CONTROL, 8'h24);
      rd_exp(ADDR_IRQ_STATUS, 8'h01);
      wr_reg(ADDR_INTERRUPT_CONTROL, 8'h04);
      `CHK({ovf, irq}, 2'b01)
      wr_reg(ADDR_IRQ_STATUS, 8'h01);
      `CHK(irq, 1'b0)
      rd_exp(ADDR_INTERRUPT_CONTROL, 8'h04);
      wr_reg(ADDR_INTERRUPT_CONTROL, 8'h00);
      @(posedge clk);
      sleep <= 1'b1;
      feed(3, 3);
      rd_exp(ADDR_TIMER_COUNT, 8'h00);
      sleep <= 1'b0;
      // every watchdog ratio; pin source with an idle pin keeps the count still, so no stray wrap
      for (int r = 0; r < 8; r++) begin
         p = 1 << r;
         wr_reg(ADDR_OPTION_CONFIG, 8'h28 | 8'(r));
         wd(0, 1'b1);
         n_post = 0;
         wd(p - 1, 1'b1);
         wd(p - 1, 1'b0);
         `CHK(n_post, 0)
         wd(p, 1'b0);
         `CHK(n_post, 1)
      end
      rd_exp(ADDR_IRQ_STATUS, 8'h02);
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule
`default_nettype wire

// ### verif/tmz_pin_src.sv
`timescale 1ns/1ps
`default_nettype none
// external pulse source on the count pin
module tmz_pin_src (
   // clock from the bench
   input wire logic clk,
   // count pin
   output logic pin
);
   initial pin = 1'b0;
   // h clocks low then h high per pulse; pin rests low between bursts
   task automatic pulses(input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge clk);
         pin <= 1'b1;
         repeat (h) @(posedge clk);
         pin <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// ### verif/tmz_timer0_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tmz_timer0_assertions
   import tmz_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // core and interrupt lines
   input wire logic sleep,
   input wire logic watchdog_clear_instr,
   input wire logic watchdog_reset,
   input wire logic overflow_irq,
   input wire logic irq
);
   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   wire logic icr_wr;
   wire logic mapped;
   assign icr_wr = wr && addr == ADDR_INTERRUPT_CONTROL;
   assign mapped = addr inside {ADDR_TIMER_COUNT, ADDR_INTERRUPT_CONTROL, ADDR_OPTION_CONFIG, ADDR_IRQ_STATUS,
      ADDR_IRQ_MASK};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
   hole_read_a: assert property (rd && !mapped |=> rdata == 8'h00) else $error("hole read nonzero");
   opt_back_a: assert property (wr && addr == ADDR_OPTION_CONFIG ##2 rd && addr == ADDR_OPTION_CONFIG
      |=> rdata == $past(wdata, 3)) else $error("option readback wrong");
   clr_pass_a: assert property (watchdog_reset == watchdog_clear_instr) else $error("clear not passed");
   flag_sticky_a: assert property ($fell(overflow_irq) |-> $past(wr)) else $error("flag dropped alone");
   irq_sticky_a: assert property ($fell(irq) |-> $past(wr)) else $error("irq dropped alone");
   enable_mask_a: assert property (icr_wr && !wdata[ICR_OVERFLOW_IRQ_ENABLE] |=> !overflow_irq)
      else $error("masked irq high");
   sleep_quiet_a: assert property ((sleep && !wr) [*4] |=> !$rose(overflow_irq)) else $error("wrap in sleep");
   // main scenarios reached
   cover property ($rose(overflow_irq));
   cover property ($fell(irq));
   cover property (sleep [*4]);
endmodule
bind tmz_timer0 tmz_timer0_assertions chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .sleep(sleep), .watchdog_clear_instr(watchdog_clear_instr), .watchdog_reset(watchdog_reset),
   .overflow_irq(overflow_irq), .irq(irq));
`default_nettype wire
